// [include/ocsw_pkg.sv]
package ocsw_pkg;

    // word layout
    localparam int WORD_W = 32;
    localparam int SEL_LO_BIT = 0;
    localparam int SEL_HI_BIT = 1;
    localparam logic [1:0] SEL_THIS_WORD = 2'h1;
    localparam int PAIRS = 5;
    localparam int PAIR_LSB = 2;
    localparam int OUTS = 10;
    localparam int MODE_W = 2;
    localparam int MODE_LSB = 7;
    localparam int REFSRC_BIT = 27;
    localparam int SHARED_BIT = 28;
    localparam int LOCK_BIT = 29;
    localparam int QDIV4_BIT = 30;
    localparam int QDIV8_BIT = 31;

    // values after power-up or power-down
    localparam logic [4:0] PAIR_SIG_RST = 5'h1F;
    localparam logic [19:0] OUT_MODE_RST = 20'h00000;
    localparam logic FLAG_RST = 1'h0;

    // serial receiver
    localparam int BITCNT_W = 6;
    localparam logic [5:0] BITCNT_FULL = 6'h20;
    localparam logic [5:0] BITCNT_MAX = 6'h3F;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        OCSW_RX_IDLE = 2'h0,
        OCSW_RX_SHIFT = 2'h1,
        OCSW_RX_DONE = 2'h3
    } ocsw_rx_e;

    typedef struct packed {
        logic quarter_shift_by_eight;
        logic quarter_shift_by_four;
        logic lock_indicator_type;
        logic shared_pin_function_select;
        logic refpin_source_select;
        logic [19:0] out_mode;
        logic [4:0] pair_signaling;
    } ocsw_cfg_s;

    typedef struct packed {
        logic ref_valid;
        logic primary_reference;
        logic digital_lock;
        logic analog_lock;
        logic oscillator_ok;
    } ocsw_stat_s;

endpackage

// [hdl/ocsw_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module ocsw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // asynchronous levels in, filtered levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_q
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [ocsw_pkg::SYNC_STAGES-1:0] stage_q;
            logic level_d;

            // a change counts only once stages two and three agree
            always_comb begin
                level_d = level_q[i];
                if (stage_q[1] == stage_q[2]) begin
                    level_d = stage_q[2];
                end
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stage_q <= '0;
                    level_q[i] <= 1'b0;
                end else begin
                    stage_q <= {stage_q[1:0], async_in[i]};
                    level_q[i] <= level_d;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [hdl/ocsw_config_word.sv]
`timescale 1ns/1ns
`default_nettype none

module ocsw_config_word (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial configuration port
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin,
    input wire logic serial_latch_pin,
    // power-down control, low powers down
    input wire logic power_down_control_n,
    // status sources from the pll core
    input wire ocsw_pkg::ocsw_stat_s status_in,
    // decoded configuration
    output ocsw_pkg::ocsw_cfg_s cfg_q,
    // status pins
    output logic refpin_state_q,
    output logic oscillator_state_pin_o,
    output logic oscillator_state_pin_oe,
    output logic pump_bias_resistor_en_q,
    output logic lock_indicator_q,
    // divider control and load pulse
    output logic quarter_div4_active_q,
    output logic quarter_div8_active_q,
    output logic div16_available_q,
    output logic pairwise_switching_q,
    output logic word_loaded_q
);

    localparam int NSYNC = 9;

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_lvl;
    logic sclk_lvl;
    logic sdata_lvl;
    logic slatch_lvl;
    logic pwrdn_n_lvl;
    ocsw_pkg::ocsw_stat_s stat_lvl;

    assign pins_raw = {serial_clk_pin, serial_data_pin, serial_latch_pin,
                       power_down_control_n, status_in};

    // every pin is foreign to clk, so all of them pass the filter
    ocsw_sync #(.W(NSYNC)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pins_raw),
        .level_q(pins_lvl)
    );

    assign sclk_lvl = pins_lvl[8];
    assign sdata_lvl = pins_lvl[7];
    assign slatch_lvl = pins_lvl[6];
    assign pwrdn_n_lvl = pins_lvl[5];
    assign stat_lvl = pins_lvl[4:0];

    // serial receiver state
    ocsw_pkg::ocsw_rx_e rx_q;
    ocsw_pkg::ocsw_rx_e rx_d;
    logic [ocsw_pkg::WORD_W-1:0] shift_q;
    logic [ocsw_pkg::WORD_W-1:0] shift_d;
    logic [ocsw_pkg::BITCNT_W-1:0] cnt_q;
    logic [ocsw_pkg::BITCNT_W-1:0] cnt_d;
    logic sclk_prev_q;
    logic slatch_prev_q;
    logic word_strobe;
    logic sclk_rise;
    logic slatch_rise;

    assign sclk_rise = sclk_lvl && !sclk_prev_q;
    assign slatch_rise = slatch_lvl && !slatch_prev_q;

    // bits shift in msb first while latch is low
    always_comb begin
        rx_d = rx_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        word_strobe = 1'b0;
        case (rx_q)
            ocsw_pkg::OCSW_RX_IDLE: begin
                cnt_d = '0;
                if (!slatch_lvl && sclk_rise) begin
                    shift_d = {shift_q[ocsw_pkg::WORD_W-2:0], sdata_lvl};
                    cnt_d = 6'h01;
                    rx_d = ocsw_pkg::OCSW_RX_SHIFT;
                end
            end
            ocsw_pkg::OCSW_RX_SHIFT: begin
                if (slatch_rise) begin
                    rx_d = ocsw_pkg::OCSW_RX_DONE;
                end else if (sclk_rise && !slatch_lvl) begin
                    shift_d = {shift_q[ocsw_pkg::WORD_W-2:0], sdata_lvl};
                    // saturate so an overlong frame never wraps to a whole word
                    if (cnt_q != ocsw_pkg::BITCNT_MAX) begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
            end
            ocsw_pkg::OCSW_RX_DONE: begin
                // short or long frames are dropped silently
                word_strobe = (cnt_q == ocsw_pkg::BITCNT_FULL);
                cnt_d = '0;
                rx_d = ocsw_pkg::OCSW_RX_IDLE;
            end
            default: begin
                rx_d = ocsw_pkg::OCSW_RX_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_q <= ocsw_pkg::OCSW_RX_IDLE;
            shift_q <= '0;
            cnt_q <= '0;
            sclk_prev_q <= 1'b0;
            slatch_prev_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            sclk_prev_q <= sclk_lvl;
            slatch_prev_q <= slatch_lvl;
        end
    end

    // configuration word
    ocsw_pkg::ocsw_cfg_s cfg_d;
    ocsw_pkg::ocsw_cfg_s cfg_dflt;
    logic addressed;
    logic loaded_d;

    always_comb begin
        cfg_dflt = '0;
        cfg_dflt.pair_signaling = ocsw_pkg::PAIR_SIG_RST;
        cfg_dflt.out_mode = ocsw_pkg::OUT_MODE_RST;
        cfg_dflt.refpin_source_select = ocsw_pkg::FLAG_RST;
        cfg_dflt.shared_pin_function_select = ocsw_pkg::FLAG_RST;
        cfg_dflt.lock_indicator_type = ocsw_pkg::FLAG_RST;
        cfg_dflt.quarter_shift_by_four = ocsw_pkg::FLAG_RST;
        cfg_dflt.quarter_shift_by_eight = ocsw_pkg::FLAG_RST;
    end

    assign addressed = ({shift_q[ocsw_pkg::SEL_HI_BIT], shift_q[ocsw_pkg::SEL_LO_BIT]}
                        == ocsw_pkg::SEL_THIS_WORD);

    always_comb begin
        cfg_d = cfg_q;
        loaded_d = 1'b0;
        if (!pwrdn_n_lvl) begin
            // held at defaults for as long as power-down stands
            cfg_d = cfg_dflt;
        end else if (word_strobe && addressed) begin
            loaded_d = 1'b1;
            cfg_d.pair_signaling = shift_q[ocsw_pkg::PAIR_LSB +: ocsw_pkg::PAIRS];
            cfg_d.out_mode = shift_q[ocsw_pkg::MODE_LSB +: ocsw_pkg::OUTS * ocsw_pkg::MODE_W];
            cfg_d.refpin_source_select = shift_q[ocsw_pkg::REFSRC_BIT];
            cfg_d.shared_pin_function_select = shift_q[ocsw_pkg::SHARED_BIT];
            cfg_d.lock_indicator_type = shift_q[ocsw_pkg::LOCK_BIT];
            cfg_d.quarter_shift_by_four = shift_q[ocsw_pkg::QDIV4_BIT];
            cfg_d.quarter_shift_by_eight = shift_q[ocsw_pkg::QDIV8_BIT];
        end
    end

    // status and divider outputs, computed from the next word so they move with it
    logic refpin_d;
    logic osc_o_d;
    logic osc_oe_d;
    logic bias_d;
    logic lock_d;
    logic q4_d;
    logic q8_d;
    logic div16_d;
    logic pairwise_d;
    logic shift_on;

    always_comb begin
        if (cfg_d.refpin_source_select) begin
            refpin_d = stat_lvl.primary_reference;
        end else begin
            refpin_d = stat_lvl.ref_valid;
        end
        // the shared pin is released when it becomes the resistor input
        osc_oe_d = !cfg_d.shared_pin_function_select;
        osc_o_d = osc_oe_d && stat_lvl.oscillator_ok;
        bias_d = cfg_d.shared_pin_function_select;
        lock_d = cfg_d.lock_indicator_type ? stat_lvl.analog_lock
                                           : stat_lvl.digital_lock;
        // both bits set cancel each other out
        q4_d = cfg_d.quarter_shift_by_four && !cfg_d.quarter_shift_by_eight;
        q8_d = cfg_d.quarter_shift_by_eight && !cfg_d.quarter_shift_by_four;
        shift_on = q4_d || q8_d;
        // either bit written takes the divider away, even the cancelled pair
        div16_d = !(cfg_d.quarter_shift_by_four || cfg_d.quarter_shift_by_eight);
        pairwise_d = shift_on;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q.pair_signaling <= ocsw_pkg::PAIR_SIG_RST;
            cfg_q.out_mode <= ocsw_pkg::OUT_MODE_RST;
            cfg_q.refpin_source_select <= ocsw_pkg::FLAG_RST;
            cfg_q.shared_pin_function_select <= ocsw_pkg::FLAG_RST;
            cfg_q.lock_indicator_type <= ocsw_pkg::FLAG_RST;
            cfg_q.quarter_shift_by_four <= ocsw_pkg::FLAG_RST;
            cfg_q.quarter_shift_by_eight <= ocsw_pkg::FLAG_RST;
            refpin_state_q <= 1'b0;
            oscillator_state_pin_o <= 1'b0;
            oscillator_state_pin_oe <= 1'b1;
            pump_bias_resistor_en_q <= 1'b0;
            lock_indicator_q <= 1'b0;
            quarter_div4_active_q <= 1'b0;
            quarter_div8_active_q <= 1'b0;
            div16_available_q <= 1'b1;
            pairwise_switching_q <= 1'b0;
            word_loaded_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            refpin_state_q <= refpin_d;
            oscillator_state_pin_o <= osc_o_d;
            oscillator_state_pin_oe <= osc_oe_d;
            pump_bias_resistor_en_q <= bias_d;
            lock_indicator_q <= lock_d;
            quarter_div4_active_q <= q4_d;
            quarter_div8_active_q <= q8_d;
            div16_available_q <= div16_d;
            pairwise_switching_q <= pairwise_d;
            word_loaded_q <= loaded_d;
        end
    end

endmodule

`default_nettype wire

// [verification/ocsw_config_word_props.sv]
`timescale 1ns/1ns
`default_nettype none

module ocsw_config_word_props (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins in
    input wire logic serial_latch_pin,
    input wire logic power_down_control_n,
    input wire ocsw_pkg::ocsw_stat_s status_in,
    // design outputs
    input wire ocsw_pkg::ocsw_cfg_s cfg_q,
    input wire logic refpin_state_q,
    input wire logic oscillator_state_pin_o,
    input wire logic oscillator_state_pin_oe,
    input wire logic pump_bias_resistor_en_q,
    input wire logic lock_indicator_q,
    input wire logic quarter_div4_active_q,
    input wire logic quarter_div8_active_q,
    input wire logic div16_available_q,
    input wire logic pairwise_switching_q,
    input wire logic word_loaded_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // status passes a synchroniser, so only judge it once settled
    sequence quiet8;
        ($stable(status_in) && $stable(cfg_q)) [*8];
    endsequence

    a_ref_pin:
    assert property (quiet8 |-> refpin_state_q == (cfg_q.refpin_source_select ?
        status_in.primary_reference : status_in.ref_valid)) else $error("ref pin wrong");
    a_lock_pick:
    assert property (quiet8 |-> lock_indicator_q == (cfg_q.lock_indicator_type ?
        status_in.analog_lock : status_in.digital_lock)) else $error("lock pick wrong");
    a_shared_pin:
    assert property (pump_bias_resistor_en_q == cfg_q.shared_pin_function_select &&
        oscillator_state_pin_oe == !pump_bias_resistor_en_q) else $error("shared pin wrong");
    a_div4_shift:
    assert property (quarter_div4_active_q == (cfg_q.quarter_shift_by_four &&
        !cfg_q.quarter_shift_by_eight)) else $error("div4 shift wrong");
    a_div8_shift:
    assert property (quarter_div8_active_q == (cfg_q.quarter_shift_by_eight &&
        !cfg_q.quarter_shift_by_four)) else $error("div8 shift wrong");
    a_div16_gone:
    assert property (div16_available_q == !(cfg_q.quarter_shift_by_four ||
        cfg_q.quarter_shift_by_eight)) else $error("div16 availability wrong");
    a_pair_switch:
    assert property (pairwise_switching_q == (quarter_div4_active_q || quarter_div8_active_q))
        else $error("pairwise switching wrong");
    a_load_pulse:
    assert property (word_loaded_q |-> serial_latch_pin ##1 !word_loaded_q)
        else $error("load pulse wrong");
    a_cfg_hold:
    assert property ($changed(cfg_q) |-> word_loaded_q || cfg_q == 30'h000001F)
        else $error("config changed without load");
    a_pwrdn_default:
    assert property (!power_down_control_n [*8] |-> cfg_q == 30'h000001F && !word_loaded_q)
        else $error("power-down default lost");

    cover property (word_loaded_q);
    cover property (cfg_q.quarter_shift_by_four && cfg_q.quarter_shift_by_eight);
    cover property (pump_bias_resistor_en_q && cfg_q.refpin_source_select);
endmodule

bind ocsw_config_word ocsw_config_word_props u_props (.clk(clk), .resetn(resetn),
    .serial_latch_pin(serial_latch_pin), .power_down_control_n(power_down_control_n),
    .status_in(status_in), .cfg_q(cfg_q), .refpin_state_q(refpin_state_q),
    .oscillator_state_pin_o(oscillator_state_pin_o),
    .oscillator_state_pin_oe(oscillator_state_pin_oe),
    .pump_bias_resistor_en_q(pump_bias_resistor_en_q), .lock_indicator_q(lock_indicator_q),
    .quarter_div4_active_q(quarter_div4_active_q), .quarter_div8_active_q(quarter_div8_active_q),
    .div16_available_q(div16_available_q), .pairwise_switching_q(pairwise_switching_q),
    .word_loaded_q(word_loaded_q));

`default_nettype wire

// [verification/ocsw_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module ocsw_host_model (
    // clock in, serial pins out
    input wire logic clk,
    output logic sclk,
    output logic sdata,
    output logic slatch
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        slatch = 1'b1;
    end

    // msb first, write only, no answer expected
    task automatic send(input logic [31:0] w, input int n);
        @(negedge clk);
        slatch = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdata = w[i];
            repeat (5) @(negedge clk);
            sclk = 1'b1;
            repeat (5) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (5) @(negedge clk);
        slatch = 1'b1;
        // no pull on the data line, so leave it at the opposite of the last bit sent
        sdata = ~sdata;
    endtask
endmodule

`default_nettype wire

// [verification/ocsw_config_word_test.sv]
`timescale 1ns/1ns
`default_nettype none

module ocsw_config_word_test;
    logic clk, resetn, pwr_dn_n, sck, sda, sle;
    ocsw_pkg::ocsw_stat_s st;
    ocsw_pkg::ocsw_cfg_s cfg;
    logic refpin, osc_o, osc_oe, rbias, lock, q4, q8, d16, pw, wl;
    int err_count = 0;
    int compares = 0;
    int loads = 0;

    ocsw_host_model host_u (.clk(clk), .sclk(sck), .sdata(sda), .slatch(sle));
    ocsw_config_word dut_u (.clk(clk), .resetn(resetn), .serial_clk_pin(sck),
        .serial_data_pin(sda), .serial_latch_pin(sle), .power_down_control_n(pwr_dn_n),
        .status_in(st), .cfg_q(cfg), .refpin_state_q(refpin), .oscillator_state_pin_o(osc_o),
        .oscillator_state_pin_oe(osc_oe), .pump_bias_resistor_en_q(rbias),
        .lock_indicator_q(lock), .quarter_div4_active_q(q4), .quarter_div8_active_q(q8),
        .div16_available_q(d16), .pairwise_switching_q(pw), .word_loaded_q(wl));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // the load pulse stands one cycle, so a count at each falling edge sees each one
    always @(negedge clk) begin
        if (wl === 1'b1) begin
            loads++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // write is blind, so allow the receive pipeline to land
    task automatic wr(input logic [31:0] w);
        host_u.send(w, 32);
        settle(12);
    endtask

    task automatic t_fields();
        logic [31:0] ws [2] = '{32'h05A5A5A5, 32'h07FFFF81};
        int l0;
        for (int i = 0; i < 2; i++) begin
            l0 = loads;
            wr(ws[i]);
            chk({cfg, 2'h1}, ws[i]);
            chk(loads - l0, 32'h00000001);
        end
    endtask

    task automatic t_select();
        logic [29:0] keep;
        int l0;
        keep = cfg;
        l0 = loads;
        for (int s = 0; s < 4; s++) begin
            if (s != 1) begin
                wr({30'h2AAAAAAA, s[1:0]});
                chk({2'h0, cfg}, {2'h0, keep});
            end
        end
        chk(loads - l0, 32'h00000000);
    endtask

    task automatic t_shift();
        for (int k = 0; k < 4; k++) begin
            wr({k[1:0], 28'h0000000, 2'h1});
            chk({q8, q4, d16, pw}, {k == 2, k == 1, k == 0, (k == 1 || k == 2)});
        end
    endtask

    task automatic t_status();
        logic [4:0] e;
        for (int k = 0; k < 8; k++) begin
            st = 5'(k * 7 + 3);
            wr({2'h0, k[2:0], 25'h0000000, 2'h1});
            e = {k[0] ? st.primary_reference : st.ref_valid,
                k[2] ? st.analog_lock : st.digital_lock, k[1], !k[1], !k[1] && st.oscillator_ok};
            chk({refpin, lock, rbias, osc_oe, osc_o}, e);
        end
    endtask

    task automatic t_refuse();
        logic [29:0] keep;
        int l0;
        keep = cfg;
        l0 = loads;
        host_u.send(32'hFFFFFFFD, 31);
        settle(12);
        chk({2'h0, cfg}, {2'h0, keep});
        chk(loads - l0, 32'h00000000);
        pwr_dn_n = 1'b0;
        settle(10);
        chk({2'h0, cfg}, 32'h0000001F);
        wr(32'hC0000001);
        pwr_dn_n = 1'b1;
        settle(10);
        chk({2'h0, cfg}, 32'h0000001F);
        chk(loads - l0, 32'h00000000);
    endtask

    task automatic wrap_up();
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        pwr_dn_n = 1'b1;
        st = '0;
        settle(16);
        chk({cfg, osc_oe, d16}, {30'h000001F, 2'h3});
        resetn = 1'b1;
        settle(6);
        t_fields();
        t_select();
        t_shift();
        t_status();
        t_refuse();
        wrap_up();
    end

    // about 6500 cycles expected; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
